// *** core/pclr_top.sv ***
// Pin configuration lock and first remap register, AXI4-Lite slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pclr_top
  import pclr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] port_config_low,
  output var  logic [31:0] ext_irq_line_select,
  output var  logic        lock_active,
  output var  logic        serial_debug_en,
  output var  logic        timer1_ch1_source_select,
  output var  logic [1:0]  i2c_map_code,
  output var  logic [1:0]  usart_map_code
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] remap_r, remap_nxt, exti_nxt, cfg_nxt;
  logic        dbg_en_nxt, tim_nxt;
  logic [1:0]  i2c_nxt, usart_nxt;
  logic        wr_go, rd_go, wr_ok, lock_wr, lock_rd;
  logic [31:0] wr_addr, wr_data;
  logic [3:0]  wr_strb;
  pclr_sel_e   wr_sel, rd_sel;
  logic        lock_key;
  logic [7:0]  pin_lock_bits;

  // Per-pin freeze mask over port_config_low
  function automatic logic [31:0] pclr_frz(input logic act, input logic [7:0] bits);
    int i;
    pclr_frz = 32'h00000000;
    for (i = 0; i < PCLR_NPINS; i++)
      pclr_frz[i*PCLR_PIN_W +: PCLR_PIN_W] = {PCLR_PIN_W{act & bits[i]}};
  endfunction : pclr_frz

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Address and data are taken in either order; write fires as soon as both have been accepted
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_go   = (aw_held_r | (s_axi_awvalid & s_axi_awready))
                 & (w_held_r | (s_axi_wvalid & s_axi_wready));
  assign wr_sel  = pclr_dec(wr_addr);
  assign wr_ok   = wr_go && wr_sel != PCLR_SEL_NONE && wr_strb == PCLR_FULL_STRB;
  assign rd_go   = s_axi_arvalid & s_axi_arready;
  assign rd_sel  = pclr_dec(s_axi_araddr);
  assign lock_wr = wr_ok && wr_sel == PCLR_SEL_LOCK;
  assign lock_rd = rd_go && rd_sel == PCLR_SEL_LOCK;

  // Bus channel next values
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = s_axi_bvalid & ~s_axi_bready;
    bresp_nxt   = s_axi_bresp;
    rvalid_nxt  = s_axi_rvalid & ~s_axi_rready;
    rresp_nxt   = s_axi_rresp;
    rdata_nxt   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      // Narrow writes are refused untouched
      if (wr_sel == PCLR_SEL_NONE)
        bresp_nxt = PCLR_RESP_DEC;
      else if (wr_strb != PCLR_FULL_STRB)
        bresp_nxt = PCLR_RESP_SLV;
      else
        bresp_nxt = PCLR_RESP_OKAY;
    end
    if (rd_go)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = (rd_sel == PCLR_SEL_NONE) ? PCLR_RESP_DEC : PCLR_RESP_OKAY;
      case (rd_sel)
        PCLR_SEL_REMAP: rdata_nxt = remap_r;
        PCLR_SEL_EXTI:  rdata_nxt = ext_irq_line_select;
        PCLR_SEL_CFG:   rdata_nxt = port_config_low;
        PCLR_SEL_LOCK:  rdata_nxt = {23'h000000, lock_key, pin_lock_bits};
        default:        rdata_nxt = 32'h00000000;
      endcase
    end
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_held_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  // Bus channel registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_r     <= 1'b0;
      awaddr_r      <= 32'h00000000;
      w_held_r      <= 1'b0;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= PCLR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= PCLR_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      aw_held_r     <= aw_held_nxt;
      awaddr_r      <= awaddr_nxt;
      w_held_r      <= w_held_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Lock sequencer
  // ----------------------------------------------------------------
  pclr_lock_seq u_lock_seq
  (
    .clk             (clk),
    .reset_n         (reset_n),
    .wr_stb          (lock_wr),
    .rd_stb          (lock_rd),
    .wr_key          (wr_data[PCLR_KEY_BIT]),
    .wr_bits         (wr_data[7:0]),
    .lock_key_r      (lock_key),
    .pin_lock_bits_r (pin_lock_bits)
  );

  // ----------------------------------------------------------------
  // Configuration and remap registers
  // ----------------------------------------------------------------
  // Register writes; decoded map codes follow the stored fields
  always_comb
  begin
    remap_nxt = remap_r;
    exti_nxt  = ext_irq_line_select;
    cfg_nxt   = port_config_low;
    if (wr_ok && wr_sel == PCLR_SEL_REMAP)
      remap_nxt = wr_data & PCLR_REMAP_MASK;
    if (wr_ok && wr_sel == PCLR_SEL_EXTI)
      exti_nxt = wr_data;
    if (wr_ok && wr_sel == PCLR_SEL_CFG)
    begin
      // Frozen nibbles keep their value, others take the write
      cfg_nxt = (port_config_low & pclr_frz(lock_key, pin_lock_bits))
              | (wr_data & ~pclr_frz(lock_key, pin_lock_bits));
    end
    // Only 100 frees the debug pin; 0xx and other codes keep it
    dbg_en_nxt = remap_nxt[PCLR_DBG_LSB +: 3] != PCLR_DBG_OFF;
    tim_nxt    = remap_nxt[PCLR_TIM_BIT];
    i2c_nxt    = {remap_nxt[PCLR_I2C_HI], remap_nxt[PCLR_I2C_LO]};
    // 00 PD4..PC2, 01 PD7/PD0/PD1, 10 PD7/PD6/PD5, 11 PC5/PC0/PC1
    usart_nxt  = {remap_nxt[PCLR_USART_HI], remap_nxt[PCLR_USART_LO]};
  end

  // Register state; reset puts the debug pin in serial debug use
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remap_r                  <= PCLR_REMAP_RST;
      ext_irq_line_select      <= PCLR_EXTI_RST;
      port_config_low          <= PCLR_CFGLOW_RST;
      lock_active              <= 1'b0;
      serial_debug_en          <= 1'b1;
      timer1_ch1_source_select <= 1'b0;
      i2c_map_code             <= 2'h0;
      usart_map_code           <= 2'h0;
    end
    else
    begin
      remap_r                  <= remap_nxt;
      ext_irq_line_select      <= exti_nxt;
      port_config_low          <= cfg_nxt;
      lock_active              <= lock_key;
      serial_debug_en          <= dbg_en_nxt;
      timer1_ch1_source_select <= tim_nxt;
      i2c_map_code             <= i2c_nxt;
      usart_map_code           <= usart_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic rd_lock_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_lock_r <= 1'b0;
    else
      rd_lock_r <= rd_go ? (rd_sel == PCLR_SEL_LOCK) : rd_lock_r;
  end

  property p_lock_read;
    s_axi_rvalid && rd_lock_r |-> s_axi_rdata[31:9] == 23'h000000;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("Lock reserved bits set");

  property p_key_read;
    lock_rd && lock_key |=> s_axi_rdata[PCLR_KEY_BIT];
  endproperty
  a_key_read: assert property (p_key_read) else $error("Lock key read wrong");

  property p_frozen;
    lock_key && pin_lock_bits[0] |=> $stable(port_config_low[3:0]);
  endproperty
  a_frozen: assert property (p_frozen) else $error("Locked pin changed");

  property p_free_write;
    wr_ok && wr_sel == PCLR_SEL_CFG && !lock_key |=> port_config_low == $past(wr_data);
  endproperty
  a_free_write: assert property (p_free_write) else $error("Config write lost");

  property p_remap_rsv;
    remap_r[31:27] == 5'h00 && remap_r[20:3] == 18'h00000 && !remap_r[0];
  endproperty
  a_remap_rsv: assert property (p_remap_rsv) else $error("Reserved remap bit set");

  property p_dbg;
    serial_debug_en == (remap_r[PCLR_DBG_LSB +: 3] != PCLR_DBG_OFF);
  endproperty
  a_dbg: assert property (p_dbg) else $error("Debug enable mismatch");

  property p_maps;
    i2c_map_code == {remap_r[PCLR_I2C_HI], remap_r[PCLR_I2C_LO]}
      && usart_map_code == {remap_r[PCLR_USART_HI], remap_r[PCLR_USART_LO]};
  endproperty
  a_maps: assert property (p_maps) else $error("Map code mismatch");

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_bresp;
    s_wr_both |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("No write response");

  property p_rlat;
    rd_go |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("No read answer");

endmodule : pclr_top
`default_nettype wire

// *** core/pclr_pkg.sv ***
// Package: addresses, field positions, reset values and codes of the pin lock/remap block
package pclr_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] PCLR_ADDR_REMAP1 = 32'h40010004;
  localparam logic [31:0] PCLR_ADDR_EXTI   = 32'h40010008;
  localparam logic [31:0] PCLR_ADDR_CFGLOW = 32'h4001000C;
  localparam logic [31:0] PCLR_ADDR_LOCK   = 32'h40010010;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCLR_NPINS    = 8;
  localparam int PCLR_PIN_W    = 4;
  localparam int PCLR_KEY_BIT  = 8;
  localparam int PCLR_DBG_LSB  = 24;
  localparam int PCLR_TIM_BIT  = 23;
  localparam int PCLR_I2C_HI   = 22;
  localparam int PCLR_USART_HI = 21;
  localparam int PCLR_USART_LO = 2;
  localparam int PCLR_I2C_LO   = 1;

  // Implemented remap bits: [26:21], 2, 1
  localparam logic [31:0] PCLR_REMAP_MASK = 32'h07E00006;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] PCLR_REMAP_RST  = 32'h00000000;
  localparam logic [31:0] PCLR_EXTI_RST   = 32'h00000000;
  localparam logic [31:0] PCLR_CFGLOW_RST = 32'h00000000;
  localparam logic [7:0]  PCLR_LOCK_RST   = 8'h00;
  localparam logic [2:0]  PCLR_DBG_OFF    = 3'h4;
  localparam logic [3:0]  PCLR_FULL_STRB  = 4'hF;
  // Pin mode codes held in each pin nibble
  localparam logic [1:0]  PCLR_MODE_IN    = 2'h0;
  localparam logic [1:0]  PCLR_MODE_10M   = 2'h1;
  localparam logic [1:0]  PCLR_MODE_2M    = 2'h2;
  localparam logic [1:0]  PCLR_MODE_30M   = 2'h3;
  localparam logic [1:0]  PCLR_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  PCLR_RESP_SLV   = 2'h2;
  localparam logic [1:0]  PCLR_RESP_DEC   = 2'h3;

  typedef enum logic [2:0] {
    PCLR_SEL_NONE, PCLR_SEL_REMAP, PCLR_SEL_EXTI, PCLR_SEL_CFG, PCLR_SEL_LOCK
  } pclr_sel_e;

  // Lock arming states, Gray coded along the arming path
  typedef enum logic [1:0] {
    PCLR_ST_IDLE = 2'h0, PCLR_ST_K1 = 2'h1, PCLR_ST_K10 = 2'h3, PCLR_ST_K101 = 2'h2
  } pclr_seq_e;

  // Address decode shared by read and write paths
  function automatic pclr_sel_e pclr_dec(input logic [31:0] addr);
    case (addr)
      PCLR_ADDR_REMAP1: pclr_dec = PCLR_SEL_REMAP;
      PCLR_ADDR_EXTI:   pclr_dec = PCLR_SEL_EXTI;
      PCLR_ADDR_CFGLOW: pclr_dec = PCLR_SEL_CFG;
      PCLR_ADDR_LOCK:   pclr_dec = PCLR_SEL_LOCK;
      default:          pclr_dec = PCLR_SEL_NONE;
    endcase
  endfunction : pclr_dec

endpackage : pclr_pkg

// *** core/pclr_lock_seq.sv ***
// Lock key arming sequencer and per-pin lock bits
`timescale 1ns/10ps
`default_nettype none
module pclr_lock_seq
  import pclr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic       wr_key,
  input  wire logic [7:0] wr_bits,
  output var  logic       lock_key_r,
  output var  logic [7:0] pin_lock_bits_r
);

  pclr_seq_e  state_r;
  pclr_seq_e  state_nxt;
  logic       lock_key_nxt;
  logic [7:0] pin_lock_bits_nxt;

  // ----------------------------------------------------------------
  // Next state of the arming sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt         = state_r;
    lock_key_nxt      = lock_key_r;
    pin_lock_bits_nxt = pin_lock_bits_r;
    if (!lock_key_r)
    begin
      if (wr_stb)
      begin
        pin_lock_bits_nxt = wr_bits;
        if (state_r != PCLR_ST_IDLE && wr_bits != pin_lock_bits_r)
          state_nxt = wr_key ? PCLR_ST_K1 : PCLR_ST_IDLE;
        else
        begin
          case (state_r)
            PCLR_ST_IDLE: state_nxt = wr_key ? PCLR_ST_K1 : PCLR_ST_IDLE;
            PCLR_ST_K1:   state_nxt = wr_key ? PCLR_ST_K1 : PCLR_ST_K10;
            PCLR_ST_K10:  state_nxt = wr_key ? PCLR_ST_K101 : PCLR_ST_IDLE;
            PCLR_ST_K101: state_nxt = wr_key ? PCLR_ST_K1 : PCLR_ST_IDLE;
            default:      state_nxt = PCLR_ST_IDLE;
          endcase
        end
      end
      else if (rd_stb)
      begin
        // The arming read returns 0, the key shows 1 from then on
        lock_key_nxt = (state_r == PCLR_ST_K101);
        state_nxt    = PCLR_ST_IDLE;
      end
    end
  end

  // Registers; only reset clears the key, the bits also take each write until locked
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r         <= PCLR_ST_IDLE;
      lock_key_r      <= 1'b0;
      pin_lock_bits_r <= PCLR_LOCK_RST;
    end
    else
    begin
      state_r         <= state_nxt;
      lock_key_r      <= lock_key_nxt;
      pin_lock_bits_r <= pin_lock_bits_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_arming_read;
    state_r == PCLR_ST_K101 && rd_stb && !wr_stb && !lock_key_r;
  endsequence

  property p_arm;
    s_arming_read |=> lock_key_r ##1 lock_key_r;
  endproperty
  a_arm: assert property (p_arm) else $error("Arming read did not lock");

  property p_rise_cause;
    $rose(lock_key_r) |-> $past(state_r) == PCLR_ST_K101 && $past(rd_stb);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("Lock without sequence");

  property p_sticky;
    lock_key_r |=> lock_key_r && $stable(pin_lock_bits_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("Lock or lock bits changed");

  property p_bits_abort;
    wr_stb && !lock_key_r && state_r != PCLR_ST_IDLE && wr_bits != pin_lock_bits_r
      |=> state_r inside {PCLR_ST_IDLE, PCLR_ST_K1};
  endproperty
  a_bits_abort: assert property (p_bits_abort) else $error("Bit change kept sequence");

endmodule : pclr_lock_seq
`default_nettype wire

// *** verification/tb_pclr_top.sv ***
// Self-checking testbench for the pin lock and remap block
`timescale 1ns/10ps
`default_nettype none
module tb_pclr_top
  import pclr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, reset_n;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, i2c_map_code, usart_map_code;
  logic [31:0] port_config_low, ext_irq_line_select;
  logic        lock_active, serial_debug_en, timer1_ch1_source_select;
  int          mismatches;
  int          checks;

  // Device under test
  pclr_top i_dut (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_config_low, .ext_irq_line_select, .lock_active, .serial_debug_en,
    .timer1_ch1_source_select, .i2c_map_code, .usart_map_code
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Ends the run when a bounded wait ran out
  task automatic give_up(input int n);
    if (n >= 200)
    begin
      mismatches++;
      $display("wait limit reached");
      final_report();
    end
  endtask : give_up

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 200)
    begin
      @(posedge clk);
      n++;
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    give_up(n);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 200);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask : axi_read

  // Full-word write expecting an OKAY response
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, PCLR_FULL_STRB, r);
    check("bresp", {30'h0, r}, {30'h0, PCLR_RESP_OKAY});
  endtask : wr

  // Read expecting an OKAY response and the given word
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check("rresp", {30'h0, r}, {30'h0, PCLR_RESP_OKAY});
    check(what, d, e);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0]  v;
    logic [31:0] d;
    logic [1:0]  r;
    clk = 1'b0;
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    mismatches = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values
    check("debug_en", {31'h0, serial_debug_en}, 32'h1);
    rd_chk("remap", PCLR_ADDR_REMAP1, PCLR_REMAP_RST);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h0);
    rd_chk("cfg", PCLR_ADDR_CFGLOW, PCLR_CFGLOW_RST);
    rd_chk("exti", PCLR_ADDR_EXTI, PCLR_EXTI_RST);
    wr(PCLR_ADDR_EXTI, 32'hA5A55A5A);
    rd_chk("exti", PCLR_ADDR_EXTI, 32'hA5A55A5A);
    check("exti_out", ext_irq_line_select, 32'hA5A55A5A);
    $display("reset values done");
    // Every remap field code, reserved bits written as ones
    for (int i = 0; i < 8; i++)
    begin
      v = 3'(i);
      d = {5'h0, v, v[0], v[1], v[2], 18'h0, v[1], v[0], 1'b0};
      wr(PCLR_ADDR_REMAP1, d | 32'hF81FFFF9);
      rd_chk("remap", PCLR_ADDR_REMAP1, d);
      check("debug_en", {31'h0, serial_debug_en}, {31'h0, v != PCLR_DBG_OFF});
      check("tim_sel", {31'h0, timer1_ch1_source_select}, {31'h0, v[0]});
      check("i2c", {30'h0, i2c_map_code}, {30'h0, v[1:0]});
      check("usart", {30'h0, usart_map_code}, {30'h0, v[2:1]});
    end
    // Part-word write and unmapped address
    axi_write(PCLR_ADDR_REMAP1, 32'h0, 4'h3, r);
    check("bresp", {30'h0, r}, {30'h0, PCLR_RESP_SLV});
    rd_chk("remap", PCLR_ADDR_REMAP1, d);
    axi_write(32'h40010000, 32'h1, PCLR_FULL_STRB, r);
    check("bresp", {30'h0, r}, {30'h0, PCLR_RESP_DEC});
    axi_read(32'h40010000, d, r);
    check("rresp", {30'h0, r}, {30'h0, PCLR_RESP_DEC});
    check("rdata", d, 32'h0);
    $display("remap fields done");
    // Broken arming sequences
    wr(PCLR_ADDR_LOCK, 32'hFFFFFE55);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h00000055);
    wr(PCLR_ADDR_LOCK, 32'h100);
    wr(PCLR_ADDR_LOCK, 32'h000);
    wr(PCLR_ADDR_LOCK, 32'h000);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h000);
    wr(PCLR_ADDR_LOCK, 32'h10F);
    wr(PCLR_ADDR_LOCK, 32'h00F);
    wr(PCLR_ADDR_LOCK, 32'h11F);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h01F);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h01F);
    $display("broken sequences done");
    // Proper arming freezes the low four pins
    wr(PCLR_ADDR_CFGLOW, 32'h32103210);
    check("cfg_out", port_config_low, 32'h32103210);
    wr(PCLR_ADDR_LOCK, 32'h10F);
    wr(PCLR_ADDR_LOCK, 32'h00F);
    wr(PCLR_ADDR_LOCK, 32'h10F);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h00F);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h10F);
    repeat (2) @(posedge clk);
    check("lock_active", {31'h0, lock_active}, 32'h1);
    wr(PCLR_ADDR_CFGLOW, 32'hFFFFFFFF);
    rd_chk("cfg", PCLR_ADDR_CFGLOW, 32'hFFFF3210);
    check("cfg_out", port_config_low, 32'hFFFF3210);
    wr(PCLR_ADDR_LOCK, 32'h0F0);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h10F);
    $display("lock armed done");
    // System reset releases the lock
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("lock_active", {31'h0, lock_active}, 32'h0);
    rd_chk("lock", PCLR_ADDR_LOCK, 32'h0);
    wr(PCLR_ADDR_CFGLOW, 32'h00000012);
    rd_chk("cfg", PCLR_ADDR_CFGLOW, 32'h00000012);
    check("debug_en", {31'h0, serial_debug_en}, 32'h1);
    $display("reset release done");
    final_report();
  end

endmodule : tb_pclr_top
`default_nettype wire
